/* design/lic_pkg.sv */
// Shared constants, types and CRC helpers for the lasered identity link.
// Assumes a 100 MHz sys_clk; every link time below is converted to cycles of it.
package lic_pkg;
   // Identity layout, family byte goes out first
   localparam int ID_BITS = 64;
   localparam int FAMILY_W = 8;
   localparam int SERIAL_W = 48;
   localparam int CRC_W = 8;
   localparam logic [7:0] CRC_INIT = 8'h00;
   localparam logic [7:0] CRC_POLY = 8'h8C; // x^8+x^5+x^4+1, bit-reversed for right shift

   // Identity selection commands
   localparam logic [7:0] CMD_READ_ID = 8'h33;
   localparam logic [7:0] CMD_MATCH_ID = 8'h55;
   localparam logic [7:0] CMD_SEARCH_ID = 8'hF0;
   localparam logic [7:0] CMD_SKIP_ID = 8'hCC;
   // Memory commands, only honoured once selected
   localparam logic [7:0] CMD_READ_MEM = 8'hF0;
   localparam logic [7:0] CMD_READ_STAT = 8'hAA;
   localparam logic [7:0] CMD_WRITE_MEM = 8'h0F;
   localparam logic [7:0] CMD_WRITE_STAT = 8'h55;
   localparam logic [7:0] CMD_READ_DATA = 8'hC3;

   // Memory organisation and erased values
   localparam int MEM_BYTES = 128;
   localparam logic [6:0] MEM_LAST = 7'h7F;
   localparam logic [2:0] STAT_LAST = 3'h7;
   localparam logic [7:0] MEM_ERASED = 8'hFF;
   localparam logic [3:0] WP_ERASED = 4'hF;
   localparam logic [7:0] STAT_FILL = 8'hFF;

   // Link timing in ns, then in cycles (minimum times rounded up)
   localparam int CNT_W = 10;
   localparam int CLK_NS = 10;
   localparam int T_RST_LOW_NS = 4800;
   localparam int T_RST_HIGH_NS = 4800;
   localparam int T_RST_DET_NS = 3000;
   localparam int T_LOW1_NS = 50;
   localparam int T_LOW0_NS = 600;
   localparam int T_SLOT_NS = 900;
   localparam int T_MSAMPLE_NS = 250;
   localparam int T_DSAMPLE_NS = 350;
   localparam int T_DHOLD_NS = 400;
   localparam int T_PD_WAIT_NS = 300;
   localparam int T_PD_LOW_NS = 1200;
   localparam int T_PD_SAMPLE_NS = 700;
   localparam int T_VPP_NS = 5000;
   localparam logic [CNT_W-1:0] C_RST_LOW = CNT_W'((T_RST_LOW_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [CNT_W-1:0] C_RST_HIGH = CNT_W'((T_RST_HIGH_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [CNT_W-1:0] C_RST_DET = CNT_W'((T_RST_DET_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [CNT_W-1:0] C_LOW1 = CNT_W'((T_LOW1_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [CNT_W-1:0] C_LOW0 = CNT_W'((T_LOW0_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [CNT_W-1:0] C_SLOT = CNT_W'((T_SLOT_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [CNT_W-1:0] C_MSAMPLE = CNT_W'((T_MSAMPLE_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [CNT_W-1:0] C_DSAMPLE = CNT_W'((T_DSAMPLE_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [CNT_W-1:0] C_DHOLD = CNT_W'((T_DHOLD_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [CNT_W-1:0] C_PD_WAIT = CNT_W'((T_PD_WAIT_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [CNT_W-1:0] C_PD_END =
      CNT_W'((T_PD_WAIT_NS + T_PD_LOW_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [CNT_W-1:0] C_PD_SAMPLE = CNT_W'((T_PD_SAMPLE_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [CNT_W-1:0] C_VPP = CNT_W'((T_VPP_NS + CLK_NS - 1) / CLK_NS);

   // Host request kinds
   typedef enum logic [1:0] {
      HQ_RESET = 2'h0,
      HQ_XFER = 2'h1,
      HQ_READ_ID = 2'h2,
      HQ_PULSE = 2'h3
   } lic_hreq_e;

   // One accumulator step: shift right, feedback folded in at the taps
   function automatic logic [7:0] lic_crc_step(input logic [7:0] c, input logic b);
      logic fb;
      fb = b ^ c[0];
      return (c >> 1) ^ (fb ? CRC_POLY : 8'h00);
   endfunction

   // Check byte over family and serial, bit 0 first
   function automatic logic [7:0] lic_crc_id(input logic [55:0] d);
      logic [7:0] c;
      c = CRC_INIT;
      for (int i = 0; i < 56; i++) begin
         c = lic_crc_step(c, d[i]);
      end
      return c;
   endfunction
endpackage

/* design/lic_if.sv */
// Single shared data line plus the programming-voltage level.
// Each end offers open-drain style out/enable; the line is high unless someone pulls low.
interface lic_if (
   input wire logic sys_clk
);
   logic m_out;
   logic m_oe_n;
   logic d_out;
   logic d_oe_n;
   logic vpp;
   logic dq;

   // Wired-AND of both ends, pulled high when nobody drives
   assign dq = (m_oe_n | m_out) & (d_oe_n | d_out);

   modport dev (input dq, input vpp, output d_out, output d_oe_n);
   modport host (input dq, output m_out, output m_oe_n, output vpp);
endinterface

/* design/lic_crc8.sv */
// Bit-serial CRC-8 accumulator used by the host to check a received identity.
// Assumes clr and en are never needed in the same cycle; clr wins.
module lic_crc8
   import lic_pkg::*;
(
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // Bit stream
   input wire logic clr,
   input wire logic en,
   input wire logic din,
   // Remainder
   output logic [7:0] crc
);
   // Cleared before a code, then one step per bit
   always_ff @(posedge sys_clk) begin
      if (rst || clr) begin
         crc <= CRC_INIT;
      end else if (en) begin
         crc <= lic_crc_step(crc, din);
      end
   end
endmodule // lic_crc8

/* design/lic_dev.sv */
// Device end: lasered identity, selection commands and add-only page memory.
// Assumes the line is sampled synchronously and the host keeps the slot timing in lic_pkg.
module lic_dev
   import lic_pkg::*;
#(
   parameter logic [7:0] FAMILY = 8'hA5, // arbitrary value
   parameter logic [47:0] SERIAL = 48'h1357_9BDF_2468 // arbitrary value
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // Line side
   lic_if.dev line,
   // User side
   output logic selected,
   output logic vpp_det,
   output logic [3:0] wp_bits,
   output logic prog_done
);
   // Fixed at build time, no write path reaches it
   localparam logic [63:0] ID = {lic_crc_id({SERIAL, FAMILY}), SERIAL, FAMILY};

   typedef enum logic [3:0] {
      D_ROMCMD = 4'h0,
      D_READID = 4'h1,
      D_MATCH = 4'h3,
      D_SEARCH = 4'h2,
      D_MEMCMD = 4'h6,
      D_ADDR = 4'h7,
      D_READ = 4'h5,
      D_WDATA = 4'h4,
      D_PROG = 4'hC,
      D_WAIT = 4'hD
   } lic_dstate_e;

   lic_dstate_e state;
   logic dq_q;
   logic fall;
   logic rst_evt;
   logic [CNT_W-1:0] low_cnt;
   logic pres_pend;
   logic pres_on;
   logic [CNT_W-1:0] pres_cnt;
   logic pres_drv;
   logic in_slot;
   logic [CNT_W-1:0] slot_cnt;
   logic slot_drv;
   logic slot_evt;
   logic rx_bit;
   logic tx_en;
   logic tx_bit;
   logic [6:0] bcnt;
   logic [1:0] step;
   logic [7:0] sh;
   logic [7:0] rx_byte;
   logic [15:0] addr;
   logic is_stat;
   logic is_wr;
   logic unlocked;
   logic vpp_rise;
   logic do_prog;
   logic [7:0] mem [MEM_BYTES];
   logic [3:0] wp;
   logic [7:0] rd_byte;

   assign fall = dq_q & ~line.dq;
   assign rst_evt = ~line.dq & (low_cnt == C_RST_DET - CNT_W'(1));
   assign pres_drv = pres_on & (pres_cnt >= C_PD_WAIT);
   assign rx_byte = {rx_bit, sh[7:1]};
   assign vpp_rise = line.vpp & ~vpp_det;
   assign do_prog = (state == D_PROG) & vpp_rise;

   // Line history and long-low detector for the host reset pulse
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         dq_q <= 1'b1;
         low_cnt <= '0;
      end else begin
         dq_q <= line.dq;
         if (line.dq) begin
            low_cnt <= '0;
         end else if (low_cnt != C_RST_DET) begin
            low_cnt <= low_cnt + CNT_W'(1);
         end
      end
   end

   // Presence acknowledge after power-up and after every reset pulse
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         pres_pend <= 1'b1;
         pres_on <= 1'b0;
         pres_cnt <= '0;
      end else if (rst_evt) begin
         pres_pend <= 1'b1;
         pres_on <= 1'b0;
      end else if (pres_pend && line.dq) begin
         pres_pend <= 1'b0;
         pres_on <= 1'b1;
         pres_cnt <= CNT_W'(1);
      end else if (pres_on) begin
         pres_cnt <= pres_cnt + CNT_W'(1);
         if (pres_cnt == C_PD_END) begin
            pres_on <= 1'b0;
         end
      end
   end

   // Bit slots: a host falling edge opens one, we may hold the line to send a zero
   always_ff @(posedge sys_clk) begin
      if (rst || rst_evt) begin
         in_slot <= 1'b0;
         slot_cnt <= '0;
         slot_drv <= 1'b0;
         slot_evt <= 1'b0;
         rx_bit <= 1'b0;
      end else begin
         slot_evt <= 1'b0;
         if (fall && !in_slot && !pres_pend && !pres_on) begin
            in_slot <= 1'b1;
            slot_cnt <= CNT_W'(1);
            slot_drv <= tx_en & ~tx_bit;
         end else if (in_slot) begin
            slot_cnt <= slot_cnt + CNT_W'(1);
            if (slot_cnt == C_DSAMPLE) begin
               rx_bit <= line.dq;
               slot_evt <= 1'b1;
            end
            if (slot_cnt == C_DHOLD) begin
               slot_drv <= 1'b0;
               in_slot <= 1'b0;
            end
         end
      end
   end

   // Open-drain drive, low enable while pulling the line down
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         line.d_oe_n <= 1'b1;
         line.d_out <= 1'b0;
      end else begin
         line.d_oe_n <= ~(pres_drv | slot_drv);
         line.d_out <= 1'b0;
      end
   end

   // Byte presented during reads
   always_comb begin
      if (is_stat) begin
         rd_byte = (addr[2:0] == 3'h0) ? {4'hF, wp} : STAT_FILL;
      end else begin
         rd_byte = mem[addr[6:0]];
      end
   end

   // What the next slot sends, if anything
   always_comb begin
      tx_en = 1'b0;
      tx_bit = 1'b1;
      case (state)
         D_READID: begin
            tx_en = 1'b1;
            tx_bit = ID[bcnt[5:0]];
         end
         D_SEARCH: begin
            tx_en = (step != 2'h2);
            tx_bit = ID[bcnt[5:0]] ^ step[0];
         end
         D_READ: begin
            tx_en = 1'b1;
            tx_bit = rd_byte[bcnt[2:0]];
         end
         default: begin
            tx_en = 1'b0;
            tx_bit = 1'b1;
         end
      endcase
   end

   // Command sequencer; a reset pulse always returns to identity selection
   always_ff @(posedge sys_clk) begin
      if (rst || rst_evt) begin
         state <= D_ROMCMD;
         bcnt <= '0;
         step <= '0;
         sh <= '0;
         addr <= '0;
         is_stat <= 1'b0;
         is_wr <= 1'b0;
         unlocked <= 1'b0;
      end else if (do_prog) begin
         addr <= addr + 16'h0001;
         state <= D_WDATA;
      end else if (slot_evt) begin
         bcnt <= bcnt + 7'h01;
         case (state)
            D_ROMCMD: begin
               sh <= rx_byte;
               if (bcnt == 7'h07) begin
                  bcnt <= '0;
                  case (rx_byte)
                     CMD_READ_ID: state <= D_READID;
                     CMD_MATCH_ID: state <= D_MATCH;
                     CMD_SEARCH_ID: state <= D_SEARCH;
                     CMD_SKIP_ID: begin
                        unlocked <= 1'b1;
                        state <= D_MEMCMD;
                     end
                     default: state <= D_WAIT;
                  endcase
               end
            end
            D_READID, D_MATCH: begin
               if (state == D_MATCH && rx_bit != ID[bcnt[5:0]]) begin
                  state <= D_WAIT;
               end else if (bcnt == 7'h3F) begin
                  bcnt <= '0;
                  unlocked <= 1'b1;
                  state <= D_MEMCMD;
               end
            end
            D_SEARCH: begin
               // Two sends, then the host's chosen direction
               if (step != 2'h2) begin
                  step <= step + 2'h1;
                  bcnt <= bcnt;
               end else begin
                  step <= 2'h0;
                  if (rx_bit != ID[bcnt[5:0]]) begin
                     state <= D_WAIT;
                  end else if (bcnt == 7'h3F) begin
                     bcnt <= '0;
                     unlocked <= 1'b1;
                     state <= D_MEMCMD;
                  end
               end
            end
            D_MEMCMD: begin
               sh <= rx_byte;
               if (bcnt == 7'h07) begin
                  bcnt <= '0;
                  is_stat <= (rx_byte == CMD_READ_STAT) || (rx_byte == CMD_WRITE_STAT);
                  is_wr <= (rx_byte == CMD_WRITE_MEM) || (rx_byte == CMD_WRITE_STAT);
                  if (!unlocked) begin
                     state <= D_WAIT;
                  end else begin
                     case (rx_byte)
                        CMD_READ_MEM, CMD_READ_STAT, CMD_WRITE_MEM,
                        CMD_WRITE_STAT, CMD_READ_DATA: state <= D_ADDR;
                        default: state <= D_WAIT;
                     endcase
                  end
               end
            end
            D_ADDR: begin
               addr <= {rx_bit, addr[15:1]};
               if (bcnt == 7'h0F) begin
                  bcnt <= '0;
                  state <= is_wr ? D_WDATA : D_READ;
               end
            end
            D_READ: begin
               if (bcnt == 7'h07) begin
                  bcnt <= '0;
                  addr <= addr + 16'h0001;
                  // Past the last byte the line just reads as ones
                  if (is_stat ? (addr[2:0] == STAT_LAST) : (addr[6:0] == MEM_LAST)) begin
                     state <= D_WAIT;
                  end
               end
            end
            D_WDATA: begin
               sh <= rx_byte;
               if (bcnt == 7'h07) begin
                  bcnt <= '0;
                  state <= D_PROG;
               end
            end
            default: bcnt <= bcnt;
         endcase
      end
   end

   // Add-only storage: a pulse can only clear bits of an unprotected page
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         for (int i = 0; i < MEM_BYTES; i++) begin
            mem[i] <= MEM_ERASED;
         end
         wp <= WP_ERASED;
         prog_done <= 1'b0;
      end else begin
         prog_done <= do_prog;
         if (do_prog && is_stat && addr[2:0] == 3'h0) begin
            wp <= wp & sh[3:0];
         end else if (do_prog && !is_stat && wp[addr[6:5]]) begin
            mem[addr[6:0]] <= mem[addr[6:0]] & sh;
         end
      end
   end

   // User-side status, programming voltage flag follows the line
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         vpp_det <= 1'b0;
         selected <= 1'b0;
         wp_bits <= WP_ERASED;
      end else begin
         vpp_det <= line.vpp;
         selected <= unlocked;
         wp_bits <= wp;
      end
   end
endmodule // lic_dev

/* design/lic_host.sv */
// Host end: reset pulses, bit slots, identity read with check, programming pulse.
// Assumes the device end keeps the slot timing in lic_pkg and one request at a time.
module lic_host
   import lic_pkg::*;
(
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // Line side
   lic_if.host line,
   // Request
   input wire logic req,
   input wire lic_hreq_e req_kind,
   input wire logic [7:0] xfer_data,
   input wire logic [3:0] xfer_bits,
   // Answer
   output logic busy,
   output logic done,
   output logic [7:0] rdata,
   output logic presence,
   output logic [63:0] id_code,
   output logic id_err
);
   typedef enum logic [2:0] {
      H_IDLE = 3'h0,
      H_RLOW = 3'h1,
      H_RHIGH = 3'h3,
      H_SLOT = 3'h2,
      H_CHECK = 3'h6,
      H_VPP = 3'h7
   } lic_hstate_e;

   lic_hstate_e state;
   logic [CNT_W-1:0] cnt;
   logic [7:0] tx;
   logic [6:0] left;
   logic id_go;
   logic id_ph;
   logic rbit;
   logic [63:0] idsh;
   logic slot_end;
   logic drv;
   logic [7:0] crc;

   assign slot_end = (state == H_SLOT) & (cnt == C_SLOT);
   assign drv = (state == H_RLOW) | ((state == H_SLOT) & (cnt < (tx[0] ? C_LOW1 : C_LOW0)));

   // Remainder over all 64 received identity bits must come out zero
   lic_crc8 u_crc (
      .sys_clk(sys_clk),
      .rst(rst),
      .clr(state == H_IDLE && req && req_kind == HQ_READ_ID),
      .en(slot_end && id_ph),
      .din(rbit),
      .crc(crc)
   );

   // Line drive; the programming pulse follows normal-level traffic
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         line.m_oe_n <= 1'b1;
         line.m_out <= 1'b0;
         line.vpp <= 1'b0;
      end else begin
         line.m_oe_n <= ~drv;
         line.m_out <= 1'b0;
         line.vpp <= (state == H_VPP);
      end
   end

   // Request sequencer
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         state <= H_IDLE;
         cnt <= '0;
         tx <= '0;
         left <= '0;
         id_go <= 1'b0;
         id_ph <= 1'b0;
         rbit <= 1'b0;
         idsh <= '0;
         busy <= 1'b0;
         done <= 1'b0;
         rdata <= '0;
         presence <= 1'b0;
         id_code <= '0;
         id_err <= 1'b0;
      end else begin
         done <= 1'b0;
         cnt <= cnt + CNT_W'(1);
         case (state)
            H_IDLE: begin
               cnt <= CNT_W'(1);
               if (req) begin
                  busy <= 1'b1;
                  case (req_kind)
                     HQ_RESET: state <= H_RLOW;
                     HQ_XFER: begin
                        tx <= xfer_data;
                        left <= (xfer_bits == 4'h0 || xfer_bits > 4'h8) ? 7'h08 : {3'h0, xfer_bits};
                        state <= H_SLOT;
                     end
                     HQ_READ_ID: begin
                        tx <= CMD_READ_ID;
                        left <= 7'h08;
                        id_go <= 1'b1;
                        state <= H_SLOT;
                     end
                     default: state <= H_VPP;
                  endcase
               end
            end
            H_RLOW: begin
               if (cnt == C_RST_LOW) begin
                  cnt <= CNT_W'(1);
                  state <= H_RHIGH;
               end
            end
            H_RHIGH: begin
               if (cnt == C_PD_SAMPLE) begin
                  presence <= ~line.dq;
               end
               if (cnt == C_RST_HIGH) begin
                  state <= H_IDLE;
                  busy <= 1'b0;
                  done <= 1'b1;
               end
            end
            H_SLOT: begin
               if (cnt == C_MSAMPLE) begin
                  rbit <= line.dq;
               end
               if (slot_end) begin
                  cnt <= CNT_W'(1);
                  tx <= {1'b1, tx[7:1]};
                  left <= left - 7'h01;
                  if (id_ph) begin
                     idsh <= {rbit, idsh[63:1]};
                  end else begin
                     rdata <= {rbit, rdata[7:1]};
                  end
                  if (left == 7'h01) begin
                     if (id_go) begin
                        // Command sent, now read all identity bits
                        id_go <= 1'b0;
                        id_ph <= 1'b1;
                        left <= 7'h40;
                        tx <= 8'hFF;
                     end else if (id_ph) begin
                        state <= H_CHECK;
                     end else begin
                        state <= H_IDLE;
                        busy <= 1'b0;
                        done <= 1'b1;
                     end
                  end
               end
            end
            H_CHECK: begin
               id_ph <= 1'b0;
               id_code <= idsh;
               id_err <= (crc != CRC_INIT);
               state <= H_IDLE;
               busy <= 1'b0;
               done <= 1'b1;
            end
            H_VPP: begin
               if (cnt == C_VPP) begin
                  state <= H_IDLE;
                  busy <= 1'b0;
                  done <= 1'b1;
               end
            end
            default: state <= H_IDLE;
         endcase
      end
   end
endmodule // lic_host

/* tb/lic_props.sv */
// Line checker: timing relations on the shared data line and programming level.
// Assumes it sits beside the interface that joins host and device ends.
module lic_props (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic m_out,
   input wire logic m_oe_n,
   input wire logic d_out,
   input wire logic d_oe_n,
   input wire logic vpp,
   input wire logic dq
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);
   logic [9:0] dl;
   logic [9:0] hl;
   // Low-stretch lengths per end; a counter keeps long holds cheap to check
   always_ff @(posedge sys_clk) begin
      dl <= d_oe_n ? 10'h000 : dl + 10'h001;
      hl <= m_oe_n ? 10'h000 : hl + 10'h001;
   end
   sequence slot_open;
      $fell(dq) && !m_oe_n;
   endsequence
   // Device sees the fall on the same edge, but slot_drv and its enable are both registered, so the pull shows at +2
   sequence dev_pull;
      ##2 !d_oe_n;
   endsequence
   AST_M_OUT: assert property (m_out == 1'b0) else $error("host data not low");
   AST_D_OUT: assert property (d_out == 1'b0) else $error("device data not low");
   AST_SLOT_END: assert property (slot_open ##0 dev_pull |-> ##[0:41] d_oe_n)
      else $error("device slot drive too long");
   AST_PRES_LEN: assert property (dl <= 10'h079) else $error("device low too long");
   AST_HOST_LEN: assert property (hl <= 10'h1E0) else $error("host low too long");
   AST_PROG_QUIET: assert property (vpp |-> d_oe_n && m_oe_n)
      else $error("line pulled during programming");
   AST_PULSE_LEN: assert property ($rose(vpp) |-> vpp[*8] ##[1:600] !vpp)
      else $error("programming pulse length");
   AST_PRES_AFTER: assert property ($rose(m_oe_n) && hl >= 10'h12C |-> ##[20:50] !d_oe_n)
      else $error("no presence after reset pulse");
endmodule // lic_props

/* tb/lasered_id_rom_crc_gate_tb.sv */
// Testbench: host and device joined by the line interface, user sides driven here.
// Assumes package timing; inputs change at the falling edge of sys_clk.
module lasered_id_rom_crc_gate_tb;
   timeunit 1ns;
   timeprecision 1ns;
   import lic_pkg::*;
   localparam logic [7:0] FAM = 8'h3C; // arbitrary value
   localparam logic [47:0] SER = 48'h0A1B_2C3D_4E5F; // arbitrary value
   logic sys_clk = 1'b0, rst = 1'b1, req = 1'b0, seen = 1'b0;
   logic sel, vdet, pdone, busy, done, pres, ierr;
   lic_hreq_e kind = HQ_RESET;
   logic [7:0] xd = 8'h00, rdata;
   logic [3:0] xb = 4'h8, wp;
   logic [63:0] id;
   int miscompares = 0, check_count = 0, pcnt = 0;
   lic_if line (.sys_clk(sys_clk));
   lic_dev #(.FAMILY(FAM), .SERIAL(SER)) lic_dev_inst (.sys_clk(sys_clk), .rst(rst),
      .line(line), .selected(sel), .vpp_det(vdet), .wp_bits(wp), .prog_done(pdone));
   lic_host lic_host_inst (.sys_clk(sys_clk), .rst(rst), .line(line), .req(req),
      .req_kind(kind), .xfer_data(xd), .xfer_bits(xb), .busy(busy), .done(done),
      .rdata(rdata), .presence(pres), .id_code(id), .id_err(ierr));
   lic_props lic_props_inst (.sys_clk(sys_clk), .rst(rst), .m_out(line.m_out),
      .m_oe_n(line.m_oe_n), .d_out(line.d_out), .d_oe_n(line.d_oe_n), .vpp(line.vpp),
      .dq(line.dq));
   // 100 MHz clock
   initial begin
      forever #5 sys_clk = ~sys_clk;
   end
   // Reference check byte, right shift with taps of x^8+x^5+x^4+1
   function automatic logic [7:0] ref_crc(input logic [63:0] d);
      logic [7:0] c;
      c = 8'h00;
      for (int i = 0; i < 56; i++) begin
         c = {d[i] ^ c[0], c[7:1]} ^ ((d[i] ^ c[0]) ? 8'h0C : 8'h00);
      end
      return c;
   endfunction
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      check_count++;
      if (got !== exp) begin
         miscompares++;
         $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   // One host request, then a bounded wait for its done pulse
   task automatic op(input lic_hreq_e k, input logic [7:0] d, input logic [3:0] n);
      int t;
      @(negedge sys_clk);
      req = 1'b1;
      kind = k;
      xd = d;
      xb = n;
      @(negedge sys_clk);
      req = 1'b0;
      chk(busy, 1'b1);
      t = 0;
      while (done !== 1'b1) begin
         @(negedge sys_clk);
         seen = seen | vdet;
         // Programming acknowledgements seen during this request
         if (pdone === 1'b1) begin
            pcnt++;
         end
         t++;
         if (t > 7000) begin
            miscompares++;
            print_verdict();
         end
      end
   endtask
   task automatic cmd(input logic sk, input logic [7:0] c, input logic [7:0] a);
      op(HQ_RESET, 8'h00, 4'h8);
      if (sk) begin
         op(HQ_XFER, CMD_SKIP_ID, 4'h8);
      end
      op(HQ_XFER, c, 4'h8);
      op(HQ_XFER, a, 4'h8);
      op(HQ_XFER, 8'h00, 4'h8);
   endtask
   task automatic rd(input logic [7:0] c, input logic [7:0] a, input logic [7:0] e);
      cmd(1'b1, c, a);
      op(HQ_XFER, 8'hFF, 4'h8);
      chk(rdata, e);
   endtask
   task automatic wr(input logic [7:0] c, input logic [7:0] a, input logic [7:0] d);
      cmd(1'b1, c, a);
      op(HQ_XFER, d, 4'h8);
      pcnt = 0;
      op(HQ_PULSE, 8'h00, 4'h8);
      chk(pcnt, 1);
   endtask
   // Main sequence
   initial begin
      logic [7:0] a;
      logic [63:0] e;
      void'($urandom(24));
      repeat (3) @(negedge sys_clk);
      rst = 1'b0;
      repeat (200) @(negedge sys_clk);
      e = {8'h00, SER, FAM};
      e[63:56] = ref_crc(e);
      op(HQ_RESET, 8'h00, 4'h8);
      chk(pres, 1'b1);
      op(HQ_READ_ID, 8'h00, 4'h8);
      chk(id, e);
      chk(ierr, 1'b0);
      op(HQ_RESET, 8'h00, 4'h8);
      chk(sel, 1'b0);
      op(HQ_XFER, CMD_MATCH_ID, 4'h8);
      for (int i = 0; i < 8; i++) begin
         op(HQ_XFER, e[8*i +: 8], 4'h8);
      end
      chk(sel, 1'b1);
      op(HQ_RESET, 8'h00, 4'h8);
      op(HQ_XFER, CMD_SEARCH_ID, 4'h8);
      for (int i = 0; i < 64; i++) begin
         op(HQ_XFER, {5'h00, e[i], 2'h3}, 4'h3);
         chk(rdata[7:5], {e[i], ~e[i], e[i]});
      end
      chk(sel, 1'b1);
      $display("test selection done");
      for (int i = 0; i < 2; i++) begin
         a = 8'(32 * (i + 1)) + 8'($urandom % 32);
         e[7:0] = 8'($urandom);
         e[15:8] = 8'($urandom);
         wr(CMD_WRITE_MEM, a, e[7:0]);
         wr(CMD_WRITE_MEM, a, e[15:8]);
         rd(i ? CMD_READ_DATA : CMD_READ_MEM, a, e[7:0] & e[15:8]);
      end
      wr(CMD_WRITE_MEM, 8'h1F, 8'h00);
      wr(CMD_WRITE_MEM, 8'h1F, 8'hFF);
      rd(CMD_READ_MEM, 8'h1F, 8'h00);
      chk(seen, 1'b1);
      $display("test programming done");
      wr(CMD_WRITE_STAT, 8'h00, 8'hFE);
      chk(wp, 4'hE);
      wr(CMD_WRITE_MEM, 8'h03, 8'h00);
      rd(CMD_READ_MEM, 8'h03, 8'hFF);
      rd(CMD_READ_STAT, 8'h00, 8'hFE);
      cmd(1'b0, CMD_READ_STAT, 8'h00);
      op(HQ_XFER, 8'hFF, 4'h8);
      chk(rdata, 8'hFF);
      $display("test protection done");
      print_verdict();
   end
endmodule // lasered_id_rom_crc_gate_tb
